// file: include/cfk_params.svh
`ifndef CFK_PARAMS_SVH
`define CFK_PARAMS_SVH
// Overview of operation
// RL1: momentary press of unlit preview key adds channel; pressing again removes it
// RL2: with interlock on, selecting preview drops every other channel from preview
// RL3: while a preview key is held, other presses add channels, interlock suspended
// RL4: while a lit key is held, pressing other lit keys removes those channels
// RL5: short press of any lit preview key clears all channels from preview; code clears all only with interlock on, else just that channel
// RL6: control bit can switch interlock off so presses accumulate channels
// RL7: preview speakers mute when operator mic is on, previewed or on record bus
// RL8: phone channel: preview pressed while talk held latches talk and preview
// RL9: with talk and preview latched, pressing either key releases both
// RL10: new source chosen while on: display alternates on-air and pending names
// RL11: pending source is taken only once the channel is switched off
// RL12: unavailable source from a profile shows a fixed not-found message
// RL13: alpha display holds 10 characters naming the assigned source
// RL14: status symbol shows channel number, or symbol during backfeed or talkback
// RL15: channel assignable to first three buses, fed post-fader post-on/off
// RL16: fourth bus post/post, record post-fader pre-on/off, phone pre/pre
// RL17: talkback key opens talkback to backfeed and shows talkback symbol
// RL18: talkback may be active on several channels at once
// RL19: auto backfeed carries bus one minus source when on, talkback when off
// RL20: direct-access keys active only after an options key, acting on that channel
// RL21: peak warning lights when peak reaches or exceeds full scale
// RL22: countdown ring shown while running, shrinking over the last 60 seconds
// RL23: fader-start: fader at bottom switches off with stop, raising gives on and start
// RL24: fader-normal: on/off and start/stop follow on and off keys only
// RL25: held key told from momentary press by a hold-time threshold in cycles
// RL26: every key is synchronised and debounced before use

// ----------------------------------------
// register map
// ----------------------------------------
`define CFK_ADR_CTRL      8'h00
`define CFK_ADR_PREVIEW   8'h04
`define CFK_ADR_ON        8'h08
`define CFK_ADR_TALK      8'h0c
`define CFK_ADR_BUS       8'h10
`define CFK_CTRL_ILK_BIT  0
`define CFK_CTRL_FSTART_BIT 1
`define CFK_CTRL_RST      2'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define CFK_CLK_HZ        40000000
`define CFK_DEB_MS        5
`define CFK_HOLD_MS       400
`define CFK_FLASH_MS      500

// ----------------------------------------
// display
// ----------------------------------------
`define CFK_ALPHA_CHARS   10
`define CFK_NOT_FOUND_TXT 80'h4e4f5420464f554e4420
`define CFK_RING_SECS     16'h003c
`endif

// file: include/cfk_pkg.sv
package cfk_pkg;
  typedef enum logic [0:0] {
    PV_IDLE   = 1'b0,
    PV_ANCHOR = 1'b1
  } cfk_pv_state_type;

  typedef enum logic [1:0] {
    SYM_CHAN     = 2'b00,
    SYM_BACKFEED = 2'b01,
    SYM_TALK     = 2'b10
  } cfk_sym_type;
endpackage : cfk_pkg

// file: rtl/cfk_fader_keys.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfk_params.svh"

module cfk_fader_keys #(
  parameter int N            = 4,
  parameter int DAK          = 6,
  parameter int CNT_W        = 25,
  parameter int PEAK_W       = 16,
  parameter int DEB_CYCLES   = (`CFK_CLK_HZ / 1000) * `CFK_DEB_MS,
  parameter int HOLD_CYCLES  = (`CFK_CLK_HZ / 1000) * `CFK_HOLD_MS,
  parameter int FLASH_CYCLES = (`CFK_CLK_HZ / 1000) * `CFK_FLASH_MS,
  parameter int CH_W         = $clog2(N),
  parameter int TXT_W        = 8 * `CFK_ALPHA_CHARS
) (
  // clock and reset
  input  wire  logic                CLOCK_I,
  input  wire  logic                RESET_I,
  // wishbone slave
  input  wire  logic                WB_CYC_I,
  input  wire  logic                WB_STB_I,
  input  wire  logic                WB_WE_I,
  input  wire  logic [7:0]          WB_ADR_I,
  input  wire  logic [3:0]          WB_SEL_I,
  input  wire  logic [31:0]         WB_DAT_I,
  output logic       [31:0]         WB_DAT_O,
  output logic                      WB_ACK_O,
  // operator keys
  input  wire  logic [N-1:0]        PREVIEW_KEY_I,
  input  wire  logic [N-1:0]        TALK_KEY_I,
  input  wire  logic [N-1:0]        ON_KEY_I,
  input  wire  logic [N-1:0]        OFF_KEY_I,
  input  wire  logic [N-1:0]        OPTIONS_KEY_I,
  input  wire  logic [4*N-1:0]      BUS_KEY_I,
  input  wire  logic [DAK-1:0]      DIRECT_KEY_I,
  input  wire  logic [N-1:0]        FADER_BOTTOM_I,
  // source attributes per channel
  input  wire  logic [N-1:0]        SRC_PHONE_I,
  input  wire  logic [N-1:0]        SRC_BACKFEED_I,
  input  wire  logic [N-1:0]        SRC_AUTO_BF_I,
  input  wire  logic [N-1:0]        SRC_OP_MIC_I,
  // source selection
  input  wire  logic                SRC_STB_I,
  input  wire  logic [CH_W-1:0]     SRC_CH_I,
  input  wire  logic [TXT_W-1:0]    SRC_NAME_I,
  input  wire  logic                SRC_FOUND_I,
  // metering and timer
  input  wire  logic [PEAK_W-1:0]   PEAK_I,
  input  wire  logic                CD_RUN_I,
  input  wire  logic [15:0]         CD_SECS_I,
  // channel state to the mixing engine
  output logic       [N-1:0]        PREVIEW_O,
  output logic                      PREVIEW_MUTE_O,
  output logic       [N-1:0]        TALK_O,
  output logic       [N-1:0]        MIX_MINUS_O,
  output logic       [N-1:0]        ON_O,
  output logic       [N-1:0]        START_O,
  output logic       [N-1:0]        STOP_O,
  output logic       [3*N-1:0]      PGM_FEED_O,
  output logic       [N-1:0]        PGM4_FEED_O,
  output logic       [N-1:0]        REC_FEED_O,
  output logic       [N-1:0]        PHONE_FEED_O,
  // direct-access keys
  output logic                      DIRECT_ACTIVE_O,
  output logic       [CH_W-1:0]     DIRECT_CH_O,
  output logic       [DAK-1:0]      DIRECT_CMD_O,
  // indicators
  output logic       [N*TXT_W-1:0]  ALPHA_TEXT_O,
  output logic       [2*N-1:0]      STATUS_SYM_O,
  output logic                      PEAK_WARN_O,
  output logic                      RING_SHOW_O,
  output logic       [5:0]          RING_FILL_O
);

  localparam int K = 9 * N + DAK;
  localparam logic [CNT_W-1:0] DEB_C   = CNT_W'(DEB_CYCLES);
  localparam logic [CNT_W-1:0] HOLD_C  = CNT_W'(HOLD_CYCLES);
  localparam logic [CNT_W-1:0] FLASH_C = CNT_W'(FLASH_CYCLES);

  // ----------------------------------------
  // key synchronise and debounce
  // ----------------------------------------
  logic [K-1:0] raw;
  logic [K-1:0] sync1_r;
  logic [K-1:0] sync2_r;
  logic [K-1:0] db_r;
  logic [K-1:0] db_q_r;
  logic [K-1:0] press;
  logic [K-1:0] release_ev;

  assign raw        = {DIRECT_KEY_I, BUS_KEY_I, OPTIONS_KEY_I, OFF_KEY_I, ON_KEY_I, TALK_KEY_I, PREVIEW_KEY_I};
  assign press      = db_r & ~db_q_r;
  assign release_ev = ~db_r & db_q_r;

  genvar g;
  generate
    for (g = 0; g < K; g++)
    begin : g_deb
      logic [CNT_W-1:0] cnt_r;
      always_ff @(posedge CLOCK_I or posedge RESET_I)
      begin
        if (RESET_I)
        begin
          sync1_r[g] <= 1'b0;
          sync2_r[g] <= 1'b0;
          db_r[g]    <= 1'b0;
          db_q_r[g]  <= 1'b0;
          cnt_r      <= '0;
        end
        else
        begin
          sync1_r[g] <= raw[g];
          sync2_r[g] <= sync1_r[g];
          db_q_r[g]  <= db_r[g];
          // a change must stand for the whole debounce time
          if (sync2_r[g] == db_r[g])
            cnt_r <= '0; // RL26
          else if (cnt_r >= DEB_C - 1'b1)
          begin
            db_r[g] <= sync2_r[g];
            cnt_r   <= '0;
          end
          else
            cnt_r <= cnt_r + 1'b1;
        end
      end
    end
  endgenerate

  logic [N-1:0]   pv_lvl;
  logic [N-1:0]   tk_lvl;
  logic [N-1:0]   pv_press;
  logic [N-1:0]   pv_rel;
  logic [N-1:0]   tk_press;
  logic [N-1:0]   on_press;
  logic [N-1:0]   off_press;
  logic [N-1:0]   opt_press;
  logic [4*N-1:0] bus_press;
  logic [DAK-1:0] dak_press;

  assign pv_lvl    = db_r[N-1:0];
  assign tk_lvl    = db_r[2*N-1:N];
  assign pv_press  = press[N-1:0];
  assign pv_rel    = release_ev[N-1:0];
  assign tk_press  = press[2*N-1:N];
  assign on_press  = press[3*N-1:2*N];
  assign off_press = press[4*N-1:3*N];
  assign opt_press = press[5*N-1:4*N];
  assign bus_press = press[9*N-1:5*N];
  assign dak_press = press[K-1:9*N];

  // ----------------------------------------
  // wishbone registers
  // ----------------------------------------
  logic [1:0]   ctrl_r;
  logic [N-1:0] pv_r;
  logic [N-1:0] on_r;
  logic [N-1:0] talk_r;
  logic [4*N-1:0] bus_r;
  logic         wb_req;
  logic         ilk;
  logic         fstart;

  assign wb_req   = WB_CYC_I & WB_STB_I;
  assign ilk      = ctrl_r[`CFK_CTRL_ILK_BIT];
  assign fstart   = ctrl_r[`CFK_CTRL_FSTART_BIT];

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
      ctrl_r   <= `CFK_CTRL_RST;
    end
    else
    begin
      // one wait state; unmapped reads return zero
      WB_ACK_O <= wb_req & ~WB_ACK_O;
      if (wb_req & ~WB_ACK_O)
      begin
        unique case (WB_ADR_I)
          `CFK_ADR_CTRL:    WB_DAT_O <= 32'(ctrl_r);
          `CFK_ADR_PREVIEW: WB_DAT_O <= 32'(pv_r);
          `CFK_ADR_ON:      WB_DAT_O <= 32'(on_r);
          `CFK_ADR_TALK:    WB_DAT_O <= 32'(talk_r);
          `CFK_ADR_BUS:     WB_DAT_O <= 32'(bus_r);
          default:          WB_DAT_O <= '0;
        endcase
      end
      if (wb_req & WB_ACK_O & WB_WE_I & WB_SEL_I[0] & (WB_ADR_I == `CFK_ADR_CTRL))
        ctrl_r <= WB_DAT_I[1:0]; // RL6
    end
  end

  // ----------------------------------------
  // preview selection and talk latch
  // ----------------------------------------
  cfk_pkg::cfk_pv_state_type st_r;
  cfk_pkg::cfk_pv_state_type st_nxt;
  logic [N-1:0]     latch_r;
  logic [N-1:0]     latch_nxt;
  logic [N-1:0]     pv_nxt;
  logic [CH_W-1:0]  anc_r;
  logic [CH_W-1:0]  anc_nxt;
  logic             anc_lit_r;
  logic             anc_lit_nxt;
  logic             used_r;
  logic             used_nxt;
  logic [CNT_W-1:0] hold_cnt_r;
  logic             ev_valid;
  logic [CH_W-1:0]  ev_ch;
  logic [N-1:0]     ev_oh;
  logic [N-1:0]     anc_oh;
  logic             anc_done;
  logic             short_lit;

  // lowest channel wins when several keys land together
  always_comb
  begin
    ev_valid = 1'b0;
    ev_ch    = '0;
    for (int i = N - 1; i >= 0; i--)
      if (pv_press[i])
      begin
        ev_valid = 1'b1;
        ev_ch    = CH_W'(i);
      end
  end

  assign ev_oh     = N'(1) << ev_ch;
  assign anc_oh    = N'(1) << anc_r;
  assign anc_done  = (st_r == cfk_pkg::PV_ANCHOR) && pv_rel[anc_r];
  assign short_lit = anc_lit_r && !used_r && (hold_cnt_r < HOLD_C);

  always_comb
  begin
    st_nxt      = st_r;
    anc_nxt     = anc_r;
    anc_lit_nxt = anc_lit_r;
    used_nxt    = used_r;
    latch_nxt   = latch_r & ~tk_press; // RL9
    pv_nxt      = pv_r & ~(tk_press & latch_r); // RL9
    if (anc_done)
    begin
      st_nxt = cfk_pkg::PV_IDLE;
      if (short_lit)
        pv_nxt = ilk ? '0 : (pv_nxt & ~anc_oh); // RL5 RL1 RL25
    end
    else if (ev_valid)
    begin
      if (latch_r[ev_ch])
      begin
        latch_nxt[ev_ch] = 1'b0; // RL9
        pv_nxt[ev_ch]    = 1'b0;
      end
      else if (tk_lvl[ev_ch] && SRC_PHONE_I[ev_ch])
      begin
        latch_nxt[ev_ch] = 1'b1; // RL8
        pv_nxt[ev_ch]    = 1'b1;
      end
      else if (st_r == cfk_pkg::PV_ANCHOR)
      begin
        // interlock suspended while the anchor key is down
        pv_nxt[ev_ch] = ~pv_r[ev_ch]; // RL3 RL4
        used_nxt      = 1'b1;
      end
      else
      begin
        st_nxt      = cfk_pkg::PV_ANCHOR;
        anc_nxt     = ev_ch;
        anc_lit_nxt = pv_r[ev_ch];
        used_nxt    = 1'b0;
        if (!pv_r[ev_ch])
          pv_nxt = ilk ? ev_oh : (pv_nxt | ev_oh); // RL1 RL2 RL6
      end
    end
    latch_nxt = latch_nxt & pv_nxt;
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      st_r      <= cfk_pkg::PV_IDLE;
      pv_r      <= '0;
      latch_r   <= '0;
      anc_r     <= '0;
      anc_lit_r <= 1'b0;
      used_r    <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      pv_r      <= pv_nxt;
      latch_r   <= latch_nxt;
      anc_r     <= anc_nxt;
      anc_lit_r <= anc_lit_nxt;
      used_r    <= used_nxt;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      hold_cnt_r <= '0;
    else if (st_r == cfk_pkg::PV_IDLE)
      hold_cnt_r <= '0; // RL25
    else if (hold_cnt_r < HOLD_C)
      hold_cnt_r <= hold_cnt_r + 1'b1;
  end

  // ----------------------------------------
  // on/off, start/stop, bus assignment
  // ----------------------------------------
  logic [N-1:0] fb_q_r;
  logic [N-1:0] fb_down;
  logic [N-1:0] fb_up;

  assign fb_down = FADER_BOTTOM_I & ~fb_q_r;
  assign fb_up   = ~FADER_BOTTOM_I & fb_q_r;

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      fb_q_r  <= '0;
      on_r    <= '0;
      START_O <= '0;
      STOP_O  <= '0;
    end
    else
    begin
      fb_q_r <= FADER_BOTTOM_I;
      if (fstart)
      begin
        on_r    <= (on_r | fb_up) & ~fb_down; // RL23
        START_O <= fb_up & ~on_r;
        STOP_O  <= fb_down & on_r;
      end
      else
      begin
        on_r    <= (on_r | on_press) & ~off_press; // RL24
        START_O <= on_press & ~off_press & ~on_r;
        STOP_O  <= off_press & on_r;
      end
    end
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
      bus_r <= '0;
    else
      bus_r <= bus_r ^ bus_press; // RL15
  end

  // ----------------------------------------
  // talkback, backfeed, feeds, preview mute
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      talk_r         <= '0;
      MIX_MINUS_O    <= '0;
      PGM_FEED_O     <= '0;
      PGM4_FEED_O    <= '0;
      REC_FEED_O     <= '0;
      PHONE_FEED_O   <= '0;
      PREVIEW_MUTE_O <= 1'b0;
    end
    else
    begin
      talk_r      <= SRC_BACKFEED_I & (tk_lvl | latch_r | (SRC_AUTO_BF_I & ~on_r)); // RL17 RL18 RL19
      MIX_MINUS_O <= SRC_BACKFEED_I & SRC_AUTO_BF_I & on_r; // RL19
      for (int i = 0; i < N; i++)
      begin
        PGM_FEED_O[3*i +: 3] <= bus_r[4*i +: 3] & {3{on_r[i]}}; // RL15
        PGM4_FEED_O[i]       <= bus_r[4*i+3] & on_r[i]; // RL16
        REC_FEED_O[i]        <= bus_r[4*i+3];
        PHONE_FEED_O[i]      <= bus_r[4*i+3];
      end
      PREVIEW_MUTE_O <= |(SRC_OP_MIC_I & (on_r | pv_r | REC_FEED_O)); // RL7
    end
  end

  assign PREVIEW_O = pv_r;
  assign TALK_O    = talk_r;
  assign ON_O      = on_r;

  // ----------------------------------------
  // direct-access keys
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      DIRECT_ACTIVE_O <= 1'b0;
      DIRECT_CH_O     <= '0;
      DIRECT_CMD_O    <= '0;
    end
    else
    begin
      for (int i = N - 1; i >= 0; i--)
        if (opt_press[i])
        begin
          DIRECT_ACTIVE_O <= 1'b1; // RL20
          DIRECT_CH_O     <= CH_W'(i);
        end
      DIRECT_CMD_O <= DIRECT_ACTIVE_O ? dak_press : '0; // RL20
    end
  end

  // ----------------------------------------
  // source take and alpha display
  // ----------------------------------------
  logic [TXT_W-1:0] cur_name_r [N];
  logic [TXT_W-1:0] pend_name_r [N];
  logic [TXT_W-1:0] alpha_r [N];
  logic [N-1:0]     pend_r;
  logic [N-1:0]     nf_r;
  logic [CNT_W-1:0] flash_cnt_r;
  logic             flash_r;

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      flash_cnt_r <= '0;
      flash_r     <= 1'b0;
    end
    else if (flash_cnt_r >= FLASH_C - 1'b1)
    begin
      flash_cnt_r <= '0;
      flash_r     <= ~flash_r;
    end
    else
      flash_cnt_r <= flash_cnt_r + 1'b1;
  end

  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      pend_r <= '0;
      nf_r   <= '0;
      for (int i = 0; i < N; i++)
      begin
        cur_name_r[i]  <= '0;
        pend_name_r[i] <= '0;
      end
    end
    else
    begin
      for (int i = 0; i < N; i++)
        if (pend_r[i] && !on_r[i])
        begin
          cur_name_r[i] <= pend_name_r[i]; // RL11
          pend_r[i]     <= 1'b0;
        end
      if (SRC_STB_I)
      begin
        nf_r[SRC_CH_I] <= ~SRC_FOUND_I; // RL12
        if (!SRC_FOUND_I)
          pend_r[SRC_CH_I] <= 1'b0;
        else if (on_r[SRC_CH_I])
        begin
          pend_r[SRC_CH_I]      <= 1'b1; // RL11
          pend_name_r[SRC_CH_I] <= SRC_NAME_I;
        end
        else
        begin
          pend_r[SRC_CH_I]     <= 1'b0;
          cur_name_r[SRC_CH_I] <= SRC_NAME_I;
        end
      end
    end
  end

  generate
    for (g = 0; g < N; g++)
    begin : g_disp
      always_ff @(posedge CLOCK_I or posedge RESET_I)
      begin
        if (RESET_I)
        begin
          alpha_r[g]           <= '0;
          STATUS_SYM_O[2*g +: 2] <= cfk_pkg::SYM_CHAN;
        end
        else
        begin
          if (nf_r[g])
            alpha_r[g] <= `CFK_NOT_FOUND_TXT; // RL12
          else if (pend_r[g] && flash_r)
            alpha_r[g] <= pend_name_r[g]; // RL10
          else
            alpha_r[g] <= cur_name_r[g]; // RL13
          if (talk_r[g])
            STATUS_SYM_O[2*g +: 2] <= cfk_pkg::SYM_TALK; // RL14 RL17
          else if (MIX_MINUS_O[g])
            STATUS_SYM_O[2*g +: 2] <= cfk_pkg::SYM_BACKFEED; // RL14
          else
            STATUS_SYM_O[2*g +: 2] <= cfk_pkg::SYM_CHAN;
        end
      end
      assign ALPHA_TEXT_O[g*TXT_W +: TXT_W] = alpha_r[g];
    end
  endgenerate

  // ----------------------------------------
  // peak warning and countdown ring
  // ----------------------------------------
  always_ff @(posedge CLOCK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      PEAK_WARN_O <= 1'b0;
      RING_SHOW_O <= 1'b0;
      RING_FILL_O <= '0;
    end
    else
    begin
      // full scale is the largest magnitude code
      PEAK_WARN_O <= (PEAK_I == {PEAK_W{1'b1}}); // RL21
      RING_SHOW_O <= CD_RUN_I; // RL22
      RING_FILL_O <= !CD_RUN_I ? 6'h00 :
                     (CD_SECS_I < `CFK_RING_SECS) ? CD_SECS_I[5:0] : 6'(`CFK_RING_SECS);
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  a_ilk_single: assert property (ilk && st_r == cfk_pkg::PV_IDLE && !anc_done && ev_valid && !pv_r[ev_ch] // RL2
    && !latch_r[ev_ch] && !(tk_lvl[ev_ch] && SRC_PHONE_I[ev_ch]) |=> pv_r == $past(ev_oh))
    else $error("interlock left other channels in preview");
  a_anchor_add: assert property (st_r == cfk_pkg::PV_ANCHOR && !anc_done && ev_valid && !latch_r[ev_ch] // RL3
    && !(tk_lvl[ev_ch] && SRC_PHONE_I[ev_ch]) |=> pv_r[$past(ev_ch)] != $past(pv_r[ev_ch]))
    else $error("press during hold did not toggle channel");
  a_short_clear: assert property (anc_done && short_lit && ilk |=> pv_r == '0) // RL5
    else $error("short lit press did not clear preview");
  a_long_keep: assert property (anc_done && anc_lit_r && hold_cnt_r >= HOLD_C && !latch_r[anc_r] // RL25
    && !tk_press[anc_r] |=> pv_r[$past(anc_r)])
    else $error("held lit key lost its preview");
  a_latch_sub: assert property ((latch_r & ~pv_r) == '0) // RL8
    else $error("talk latch without preview");
  a_latch_rel: assert property (|(tk_press & latch_r) |=> (latch_r & $past(tk_press & latch_r)) == '0) // RL9
    else $error("latched pair not released by talk");
  a_defer_take: assert property (on_r[0] |=> $stable(cur_name_r[0])) // RL11
    else $error("source taken while channel on");
  a_mute: assert property (|(SRC_OP_MIC_I & (on_r | pv_r)) |=> PREVIEW_MUTE_O) // RL7
    else $error("preview not muted for operator mic");
  a_fstart_off: assert property (fstart && fb_down[0] && on_r[0] |=> !on_r[0] && STOP_O[0]) // RL23
    else $error("fader bottom did not stop channel");
  a_normal_on: assert property (!fstart && on_press[0] && !off_press[0] |=> on_r[0] ##1 (on_r[0] || $past(off_press[0]))) // RL24
    else $error("on key ignored in fader-normal");
  a_peak_warn: assert property (PEAK_I == {PEAK_W{1'b1}} |=> PEAK_WARN_O) // RL21
    else $error("peak warning missing at full scale");
  a_ring_fill: assert property (CD_RUN_I && CD_SECS_I < `CFK_RING_SECS |=> RING_FILL_O == $past(CD_SECS_I[5:0])) // RL22
    else $error("ring fill wrong in last minute");
  a_wb_ack: assert property (wb_req && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("wishbone ack not a single cycle");

  c_multi_pv: cover property (st_r == cfk_pkg::PV_ANCHOR && $countones(pv_r) > 1);
  c_latch: cover property (latch_r != '0);
  c_pending: cover property (pend_r[0] && on_r[0] ##[1:1000] !pend_r[0]);
  c_auto_talk: cover property (MIX_MINUS_O[0] ##[1:1000] talk_r[0]);

endmodule : cfk_fader_keys

`default_nettype wire

// file: verification/cfk_key_panel.sv
`timescale 1ns/1ps
`default_nettype none
module cfk_key_panel (
  // clock
  input  wire logic       clk_i,
  // preview key levels to the design
  output logic      [3:0] key_o
);
  initial key_o = 4'h0;
  // ------------------------------
  // key action
  // ------------------------------
  // level held 12 cycles: longer than sync plus debounce, so every edge registers
  task automatic set_key(input int ch, input logic lvl);
    @(posedge clk_i);
    key_o[ch] <= lvl;
    repeat (12) @(posedge clk_i);
  endtask : set_key
endmodule : cfk_key_panel
`default_nettype wire

// file: verification/console_fader_key_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfk_params.svh"
module console_fader_key_logic_tb;
  logic CLOCK_I, RESET_I, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, SRC_STB_I, SRC_FOUND_I, CD_RUN_I;
  logic PREVIEW_MUTE_O, DIRECT_ACTIVE_O, PEAK_WARN_O, RING_SHOW_O;
  logic [7:0]   WB_ADR_I, STATUS_SYM_O;
  logic [3:0]   WB_SEL_I, PREVIEW_KEY_I, TALK_KEY_I, ON_KEY_I, OFF_KEY_I, OPTIONS_KEY_I, FADER_BOTTOM_I;
  logic [3:0]   SRC_PHONE_I, SRC_BACKFEED_I, SRC_AUTO_BF_I, SRC_OP_MIC_I, PREVIEW_O, TALK_O, MIX_MINUS_O;
  logic [3:0]   ON_O, START_O, STOP_O, PGM4_FEED_O, REC_FEED_O, PHONE_FEED_O;
  logic [31:0]  WB_DAT_I, WB_DAT_O, q;
  logic [15:0]  BUS_KEY_I, PEAK_I, CD_SECS_I;
  logic [5:0]   DIRECT_KEY_I, DIRECT_CMD_O, RING_FILL_O;
  logic [1:0]   SRC_CH_I, DIRECT_CH_O;
  logic [79:0]  SRC_NAME_I;
  logic [11:0]  PGM_FEED_O;
  logic [319:0] ALPHA_TEXT_O;
  int           error_cnt, num_checks;
  // short counts keep the run brief
  cfk_fader_keys #(.DEB_CYCLES(4), .HOLD_CYCLES(20), .FLASH_CYCLES(8)) cfk_fader_keys_i (.*);
  cfk_key_panel cfk_key_panel_i (.clk_i(CLOCK_I), .key_o(PREVIEW_KEY_I));
  // ------------------------------
  // clock and watchdog
  // ------------------------------
  initial
  begin
    CLOCK_I = 1'b0;
    forever #12.5 CLOCK_I = ~CLOCK_I;
  end
  initial
  begin
    repeat (4000) @(posedge CLOCK_I);
    error_cnt++;
    end_of_test();
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic end_of_test;
    if (error_cnt == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK_I);
  endtask : cyc
  // classic cycle: hold until ack, release after it
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d, output logic [31:0] r);
    @(posedge CLOCK_I);
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I} <= {2'b11, we, adr, d};
    do @(posedge CLOCK_I); while (WB_ACK_O !== 1'b1);
    r = WB_DAT_O;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
  endtask : wb
  task automatic tap(input int ch);
    cfk_key_panel_i.set_key(ch, 1'b1);
    cfk_key_panel_i.set_key(ch, 1'b0);
  endtask : tap
  task automatic src(input logic [1:0] ch, input logic [79:0] nm, input logic fnd);
    @(posedge CLOCK_I);
    {SRC_STB_I, SRC_CH_I, SRC_NAME_I, SRC_FOUND_I} <= {1'b1, ch, nm, fnd};
    @(posedge CLOCK_I);
    SRC_STB_I <= 1'b0;
    cyc(3);
  endtask : src
  // ------------------------------
  // tests
  // ------------------------------
  initial
  begin
    error_cnt = 0;
    num_checks = 0;
    {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_DAT_I, SRC_STB_I, SRC_FOUND_I, CD_RUN_I} = '0;
    {TALK_KEY_I, ON_KEY_I, OFF_KEY_I, OPTIONS_KEY_I, FADER_BOTTOM_I, BUS_KEY_I, DIRECT_KEY_I} = '0;
    {SRC_PHONE_I, SRC_BACKFEED_I, SRC_AUTO_BF_I, SRC_OP_MIC_I, PEAK_I, CD_SECS_I} = '0;
    {SRC_CH_I, SRC_NAME_I} = '0;
    WB_SEL_I = 4'hf;
    RESET_I = 1'b1;
    cyc(10);
    RESET_I <= 1'b0;
    wb(1'b0, 8'h00, 32'h0, q); chk(q, 80'h1);
    wb(1'b1, 8'h14, 32'h3, q);
    wb(1'b0, 8'h14, 32'h0, q); chk(q, 80'h0);
    tap(1); chk(PREVIEW_O, 80'h2);
    tap(2); chk(PREVIEW_O, 80'h4);
    // long hold on ch0 while ch3 joins, release after hold keeps the mix
    cfk_key_panel_i.set_key(0, 1'b1);
    tap(3); chk(PREVIEW_O, 80'h9);
    cfk_key_panel_i.set_key(0, 1'b0); chk(PREVIEW_O, 80'h9);
    tap(0); chk(PREVIEW_O, 80'h0);
    cfk_key_panel_i.set_key(1, 1'b1);
    tap(2); chk(PREVIEW_O, 80'h6);
    tap(2); chk(PREVIEW_O, 80'h2);
    cfk_key_panel_i.set_key(1, 1'b0);
    wb(1'b1, 8'h00, 32'h0, q);
    tap(0); chk(PREVIEW_O, 80'h3);
    wb(1'b0, 8'h04, 32'h0, q); chk(q, 80'h3);
    @(posedge CLOCK_I);
    SRC_OP_MIC_I <= 4'h1;
    cyc(4); chk(PREVIEW_MUTE_O, 80'h1);
    PEAK_I <= 16'hffff;
    cyc(3); chk(PEAK_WARN_O, 80'h1);
    PEAK_I <= 16'hfffe;
    cyc(3); chk(PEAK_WARN_O, 80'h0);
    src(2'h2, "MIC TWO   ", 1'b1); chk(ALPHA_TEXT_O[160+:80], "MIC TWO   ");
    src(2'h3, "GONE LINE ", 1'b0); chk(ALPHA_TEXT_O[240+:80], `CFK_NOT_FOUND_TXT);
    // on key, bus 1 and bus 4 on ch0, options on ch2
    ON_KEY_I <= 4'h1;
    BUS_KEY_I <= 16'h0009;
    OPTIONS_KEY_I <= 4'h4;
    cyc(12);
    ON_KEY_I <= 4'h0;
    BUS_KEY_I <= 16'h0000;
    OPTIONS_KEY_I <= 4'h0;
    cyc(12);
    chk(ON_O, 80'h1);
    chk(PGM_FEED_O, 80'h1);
    chk(PGM4_FEED_O, 80'h1);
    chk(REC_FEED_O, 80'h1);
    chk(DIRECT_ACTIVE_O, 80'h1);
    chk(DIRECT_CH_O, 80'h2);
    // talk on ch1, auto backfeed on ch0, source change while ch0 is on
    SRC_BACKFEED_I <= 4'h3;
    SRC_AUTO_BF_I <= 4'h1;
    TALK_KEY_I <= 4'h2;
    src(2'h0, "NEW ONE   ", 1'b1);
    cyc(12);
    chk(TALK_O, 80'h2);
    chk(MIX_MINUS_O, 80'h1);
    chk(STATUS_SYM_O, 80'h09);
    chk(ALPHA_TEXT_O[79:0] == "NEW ONE   ", 80'h0);
    OFF_KEY_I <= 4'h1;
    TALK_KEY_I <= 4'h0;
    cyc(12);
    OFF_KEY_I <= 4'h0;
    cyc(12);
    chk(TALK_O, 80'h1);
    chk(ALPHA_TEXT_O[79:0], "NEW ONE   ");
    chk(PGM_FEED_O, 80'h0);
    chk(REC_FEED_O, 80'h1);
    CD_SECS_I <= 16'h001e;
    CD_RUN_I <= 1'b1;
    cyc(3);
    chk(RING_SHOW_O, 80'h1);
    chk(RING_FILL_O, 80'h1e);
    end_of_test();
  end
endmodule : console_fader_key_logic_tb
`default_nettype wire
